/* File: hw/ftc_edge_div.sv */
/*
 * ftc_edge_div: divides a sampled clock level by an integer ratio.
 * assumes level_in is already synchronous to clk_in and toggles well below
 * half the system clock rate.
 */
`timescale 1ns/1ps
module ftc_edge_div #(
  parameter int W = 7
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // divider control
  input wire logic level_in,
  input wire logic [W-1:0] ratio_in,
  // divided clock
  output logic clock_out
);

  logic prev;
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic rise;

  assign rise = level_in & ~prev;
  assign next_cnt = (cnt >= ratio_in - W'(1)) ? '0 : cnt + W'(1);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prev <= 1'b0;
    end else begin
      prev <= level_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
    end else if (rise) begin
      cnt <= next_cnt;
    end
  end

  // high for the first half of each ratio-long run of input edges
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clock_out <= 1'b0;
    end else if (ratio_in <= W'(1)) begin
      clock_out <= level_in;
    end else if (rise) begin
      clock_out <= (next_cnt < (ratio_in >> 1));
    end
  end

  a_count_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (rise && ratio_in > W'(1) && cnt >= ratio_in - W'(1)) |=> (cnt == '0))
    else $error("divider count did not wrap at ratio");

  a_unity_pass: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ratio_in == W'(1)) |=> (clock_out == $past(level_in)))
    else $error("unity ratio does not pass the input level");

endmodule

/* File: hw/ftc_fll_two_ctrl.sv */
/*
 * ftc_fll_two_ctrl: configuration registers and clock steering for the
 * second frequency-locked loop, reached over an Avalon-MM slave.
 * assumes clock pins toggle below 50 MHz (they are sampled at 100 MHz) and
 * that the analogue oscillator and loop filter sit outside this block.
 */
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
module ftc_fll_two_ctrl
  import ftc_pkg::*;
#(
  parameter int DIV_W = 7
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // avalon-mm slave
  input wire logic [11:0] ADDRESS_IN,
  input wire logic READ_IN,
  input wire logic WRITE_IN,
  input wire logic [31:0] WRITEDATA_IN,
  input wire logic [3:0] BYTEENABLE_IN,
  output logic [31:0] READDATA_OUT,
  output logic WAITREQUEST_OUT,
  // clock pins
  input wire logic MASTER_CLOCK_IN_A_IN,
  input wire logic MASTER_CLOCK_IN_B_IN,
  input wire logic FRAME_CLOCK_PORT_B_IN,
  input wire logic BIT_CLOCK_PORT_B_IN,
  input wire logic OSCILLATOR_CLOCK_IN,
  // loop control from the analogue loop
  input wire logic [5:0] NORMAL_CONTROL_IN,
  // derived clocks
  output logic SYNTH_OUTPUT_CLOCK_OUT,
  output logic REFERENCE_INPUT_CLOCK_OUT,
  output logic FEEDBACK_CLOCK_OUT,
  // oscillator and ratio settings
  output logic [5:0] OSCILLATOR_CONTROL_OUT,
  output logic [9:0] INTEGER_MULTIPLIER_OUT,
  output logic [15:0] FRACTION_NUMERATOR_OUT,
  output logic [15:0] FRACTION_DENOMINATOR_OUT,
  output logic FRACTIONAL_MODE_SELECT_OUT,
  output logic LOOP_BYPASS_SELECT_OUT
);

  // configuration fields
  logic [5:0] output_divide_ratio;
  logic [2:0] oscillator_ratio_divide;
  logic [15:0] fraction_numerator;
  logic [9:0] integer_multiplier;
  logic loop_bypass_select;
  logic [5:0] forced_oscillator_value;
  logic forced_oscillator_select;
  logic [1:0] reference_predivider;
  ftc_src_t reference_source_select;
  logic [15:0] fraction_denominator;
  logic fractional_mode_select;
  logic [1:0] mode_reserved;

  // bus decode
  logic [9:0] reg_idx;
  logic mapped;
  logic [15:0] cur_word;
  logic [15:0] wr_word;
  logic wr_take;

  // clock path
  logic [FTC_PIN_COUNT-1:0] pin_raw;
  logic [FTC_PIN_COUNT-1:0] sync1;
  logic [FTC_PIN_COUNT-1:0] sync2;
  logic ref_lvl;
  logic [DIV_W-1:0] ref_ratio;
  logic [DIV_W-1:0] fb_ratio;
  logic [DIV_W-1:0] out_ratio;
  logic out_div_clk;

  assign reg_idx = ADDRESS_IN[11:2];
  assign wr_take = WRITE_IN && !WAITREQUEST_OUT;

  function automatic logic [15:0] merge_lanes(input logic [15:0] old_word, input logic [31:0] wdata,
                                              input logic [3:0] be);
    logic [15:0] res;
    res = old_word;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // readback; unused bits read zero
  always_comb begin
    cur_word = 16'h0000;
    mapped = 1'b1;
    case (reg_idx)
      FTC_IDX_OUT_DIV: begin
        cur_word[FTC_OUTDIV_MSB:FTC_OUTDIV_LSB] = output_divide_ratio;
        cur_word[FTC_FRATIO_MSB:FTC_FRATIO_LSB] = oscillator_ratio_divide;
      end
      FTC_IDX_FRAC_NUM: begin
        cur_word = fraction_numerator;
      end
      FTC_IDX_INT_MULT: begin
        cur_word[FTC_INTMUL_MSB:FTC_INTMUL_LSB] = integer_multiplier;
      end
      FTC_IDX_REF_SEL: begin
        cur_word[FTC_BYPASS_BIT] = loop_bypass_select;
        cur_word[FTC_NCOVAL_MSB:FTC_NCOVAL_LSB] = forced_oscillator_value;
        cur_word[FTC_FORCED_BIT] = forced_oscillator_select;
        cur_word[FTC_REFDIV_MSB:FTC_REFDIV_LSB] = reference_predivider;
        cur_word[FTC_REFSRC_MSB:FTC_REFSRC_LSB] = reference_source_select;
      end
      FTC_IDX_FRAC_DEN: begin
        cur_word = fraction_denominator;
      end
      FTC_IDX_FRAC_MODE: begin
        cur_word[FTC_RSVD_MSB:FTC_RSVD_LSB] = mode_reserved;
        cur_word[FTC_FRACEN_BIT] = fractional_mode_select;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign wr_word = merge_lanes(cur_word, WRITEDATA_IN, BYTEENABLE_IN);

  // one wait cycle per access keeps read data registered
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      WAITREQUEST_OUT <= 1'b1;
    end else if (!WAITREQUEST_OUT) begin
      WAITREQUEST_OUT <= 1'b1;
    end else if (READ_IN || WRITE_IN) begin
      WAITREQUEST_OUT <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      READDATA_OUT <= 32'h0000_0000;
    end else if (READ_IN && WAITREQUEST_OUT) begin
      READDATA_OUT <= {16'h0000, cur_word};
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      output_divide_ratio <= FTC_OUTDIV_RST;
      oscillator_ratio_divide <= FTC_FRATIO_RST;
    end else if (wr_take && reg_idx == FTC_IDX_OUT_DIV) begin
      output_divide_ratio <= wr_word[FTC_OUTDIV_MSB:FTC_OUTDIV_LSB];
      oscillator_ratio_divide <= wr_word[FTC_FRATIO_MSB:FTC_FRATIO_LSB];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      fraction_numerator <= FTC_FRACNUM_RST;
    end else if (wr_take && reg_idx == FTC_IDX_FRAC_NUM) begin
      fraction_numerator <= wr_word;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      integer_multiplier <= FTC_INTMUL_RST;
    end else if (wr_take && reg_idx == FTC_IDX_INT_MULT) begin
      integer_multiplier <= wr_word[FTC_INTMUL_MSB:FTC_INTMUL_LSB];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      loop_bypass_select <= FTC_BYPASS_RST;
      forced_oscillator_value <= FTC_NCOVAL_RST;
      forced_oscillator_select <= FTC_FORCED_RST;
      reference_predivider <= FTC_REFDIV_RST;
      reference_source_select <= ftc_src_t'(FTC_REFSRC_RST);
    end else if (wr_take && reg_idx == FTC_IDX_REF_SEL) begin
      loop_bypass_select <= wr_word[FTC_BYPASS_BIT];
      forced_oscillator_value <= wr_word[FTC_NCOVAL_MSB:FTC_NCOVAL_LSB];
      forced_oscillator_select <= wr_word[FTC_FORCED_BIT];
      reference_predivider <= wr_word[FTC_REFDIV_MSB:FTC_REFDIV_LSB];
      reference_source_select <= ftc_src_t'(wr_word[FTC_REFSRC_MSB:FTC_REFSRC_LSB]);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      fraction_denominator <= FTC_FRACDEN_RST;
    end else if (wr_take && reg_idx == FTC_IDX_FRAC_DEN) begin
      fraction_denominator <= wr_word;
    end
  end

  // reserved bits are stored so readback matches what was written
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      fractional_mode_select <= FTC_FRACEN_RST;
      mode_reserved <= FTC_RSVD_RST;
    end else if (wr_take && reg_idx == FTC_IDX_FRAC_MODE) begin
      fractional_mode_select <= wr_word[FTC_FRACEN_BIT];
      mode_reserved <= wr_word[FTC_RSVD_MSB:FTC_RSVD_LSB];
    end
  end

  // pin synchronisers
  assign pin_raw[FTC_PIN_MCLK_A] = MASTER_CLOCK_IN_A_IN;
  assign pin_raw[FTC_PIN_MCLK_B] = MASTER_CLOCK_IN_B_IN;
  assign pin_raw[FTC_PIN_FRAME_B] = FRAME_CLOCK_PORT_B_IN;
  assign pin_raw[FTC_PIN_BIT_B] = BIT_CLOCK_PORT_B_IN;
  assign pin_raw[FTC_PIN_OSC] = OSCILLATOR_CLOCK_IN;

  for (genvar g = 0; g < FTC_PIN_COUNT; g++) begin : g_sync
    always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
        sync1[g] <= 1'b0;
        sync2[g] <= 1'b0;
      end else begin
        sync1[g] <= pin_raw[g];
        sync2[g] <= sync1[g];
      end
    end
  end

  always_comb begin
    case (reference_source_select)
      FTC_SRC_MCLK_A: ref_lvl = sync2[FTC_PIN_MCLK_A];
      FTC_SRC_MCLK_B: ref_lvl = sync2[FTC_PIN_MCLK_B];
      FTC_SRC_FRAME_B: ref_lvl = sync2[FTC_PIN_FRAME_B];
      FTC_SRC_BIT_B: ref_lvl = sync2[FTC_PIN_BIT_B];
      default: ref_lvl = sync2[FTC_PIN_MCLK_A];
    endcase
  end

  // ratio decodes
  assign ref_ratio = DIV_W'(1) << reference_predivider;
  assign fb_ratio = oscillator_ratio_divide[2] ? DIV_W'(FTC_FRATIO_MAX) :
                    DIV_W'(1) << oscillator_ratio_divide[1:0];
  // reserved codes fall back to the smallest legal ratio rather than stopping
  assign out_ratio = (output_divide_ratio < FTC_OUTDIV_MIN_CODE) ? DIV_W'(FTC_OUTDIV_FALLBACK) :
                     DIV_W'(output_divide_ratio) + DIV_W'(1);

  ftc_edge_div #(.W(DIV_W)) u_ref_div (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .level_in(ref_lvl),
    .ratio_in(ref_ratio),
    .clock_out(REFERENCE_INPUT_CLOCK_OUT)
  );

  ftc_edge_div #(.W(DIV_W)) u_fb_div (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .level_in(sync2[FTC_PIN_OSC]),
    .ratio_in(fb_ratio),
    .clock_out(FEEDBACK_CLOCK_OUT)
  );

  ftc_edge_div #(.W(DIV_W)) u_out_div (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .level_in(sync2[FTC_PIN_OSC]),
    .ratio_in(out_ratio),
    .clock_out(out_div_clk)
  );

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      SYNTH_OUTPUT_CLOCK_OUT <= 1'b0;
    end else if (loop_bypass_select) begin
      SYNTH_OUTPUT_CLOCK_OUT <= sync2[FTC_PIN_BIT_B];
    end else begin
      SYNTH_OUTPUT_CLOCK_OUT <= out_div_clk;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      OSCILLATOR_CONTROL_OUT <= FTC_NCOVAL_RST;
    end else if (forced_oscillator_select) begin
      OSCILLATOR_CONTROL_OUT <= forced_oscillator_value;
    end else begin
      OSCILLATOR_CONTROL_OUT <= NORMAL_CONTROL_IN;
    end
  end

  assign INTEGER_MULTIPLIER_OUT = integer_multiplier;
  assign FRACTION_NUMERATOR_OUT = fraction_numerator;
  assign FRACTION_DENOMINATOR_OUT = fraction_denominator;
  assign FRACTIONAL_MODE_SELECT_OUT = fractional_mode_select;
  assign LOOP_BYPASS_SELECT_OUT = loop_bypass_select;

  a_outdiv_decode: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (output_divide_ratio >= FTC_OUTDIV_MIN_CODE) |-> (out_ratio == DIV_W'(output_divide_ratio) + DIV_W'(1)))
    else $error("output divider ratio is not code plus one");

  a_fratio_decode: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    oscillator_ratio_divide[2] |-> (fb_ratio == DIV_W'(16)))
    else $error("oscillator ratio 1XX does not divide by 16");

  a_predivide_decode: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (reference_predivider == 2'h3) |-> (ref_ratio == DIV_W'(8)))
    else $error("reference predivider 11 does not divide by 8");

  a_bypass_path: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    loop_bypass_select |=> (SYNTH_OUTPUT_CLOCK_OUT == $past(sync2[FTC_PIN_BIT_B])))
    else $error("bypass does not route the bit clock");

  a_forced_drive: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    forced_oscillator_select |=>
    (OSCILLATOR_CONTROL_OUT == $past(forced_oscillator_value)))
    else $error("forced mode does not drive the forced value");

  a_source_pick: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (reference_source_select == FTC_SRC_FRAME_B) |-> (ref_lvl == sync2[FTC_PIN_FRAME_B]))
    else $error("reference source 10 does not pick frame clock b");

  a_reset_defaults: assert property (@(posedge CLK_IN)
    !RST_N_IN |=> (forced_oscillator_value == 6'h19 && mode_reserved == 2'h3 && !fractional_mode_select))
    else $error("reset does not restore default fields");

  a_numerator_write: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (wr_take && reg_idx == FTC_IDX_FRAC_NUM && BYTEENABLE_IN[1:0] == 2'h3) |=>
    (FRACTION_NUMERATOR_OUT == $past(WRITEDATA_IN[15:0])))
    else $error("numerator write not stored");

  a_bus_answer: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ((READ_IN || WRITE_IN) && WAITREQUEST_OUT) |=> !WAITREQUEST_OUT ##1 WAITREQUEST_OUT)
    else $error("bus answer not one cycle after request");

  a_unmapped_zero: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (READ_IN && WAITREQUEST_OUT && !mapped) |=> (READDATA_OUT == 32'h0000_0000))
    else $error("unmapped read not zero");

  c_fractional_mode: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    $rose(fractional_mode_select));
  c_bypass_on: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    loop_bypass_select && $rose(SYNTH_OUTPUT_CLOCK_OUT));
  c_forced_on: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    $rose(forced_oscillator_select));
  c_divided_out: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !loop_bypass_select && $rose(SYNTH_OUTPUT_CLOCK_OUT));

endmodule

/* File: hw/ftc_pkg.sv */
/*
 * ftc_pkg: register indices, field positions, reset values and enumerations
 * for the second loop's configuration block.
 * assumes a 32-bit word-addressed bus where byte address = 4 * register index.
 */
package ftc_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] FTC_IDX_OUT_DIV = 10'h241;
  localparam logic [9:0] FTC_IDX_FRAC_NUM = 10'h242;
  localparam logic [9:0] FTC_IDX_INT_MULT = 10'h243;
  localparam logic [9:0] FTC_IDX_REF_SEL = 10'h244;
  localparam logic [9:0] FTC_IDX_FRAC_DEN = 10'h246;
  localparam logic [9:0] FTC_IDX_FRAC_MODE = 10'h247;

  // field positions
  localparam int FTC_OUTDIV_LSB = 8;
  localparam int FTC_OUTDIV_MSB = 13;
  localparam int FTC_FRATIO_LSB = 0;
  localparam int FTC_FRATIO_MSB = 2;
  localparam int FTC_INTMUL_LSB = 5;
  localparam int FTC_INTMUL_MSB = 14;
  localparam int FTC_BYPASS_BIT = 15;
  localparam int FTC_NCOVAL_LSB = 7;
  localparam int FTC_NCOVAL_MSB = 12;
  localparam int FTC_FORCED_BIT = 6;
  localparam int FTC_REFDIV_LSB = 3;
  localparam int FTC_REFDIV_MSB = 4;
  localparam int FTC_REFSRC_LSB = 0;
  localparam int FTC_REFSRC_MSB = 1;
  localparam int FTC_FRACEN_BIT = 0;
  localparam int FTC_RSVD_LSB = 1;
  localparam int FTC_RSVD_MSB = 2;

  // reset values
  localparam logic [5:0] FTC_OUTDIV_RST = 6'h00;
  localparam logic [2:0] FTC_FRATIO_RST = 3'h0;
  localparam logic [15:0] FTC_FRACNUM_RST = 16'h0000;
  localparam logic [9:0] FTC_INTMUL_RST = 10'h000;
  localparam logic FTC_BYPASS_RST = 1'b0;
  localparam logic [5:0] FTC_NCOVAL_RST = 6'h19;
  localparam logic FTC_FORCED_RST = 1'b0;
  localparam logic [1:0] FTC_REFDIV_RST = 2'h0;
  localparam logic [1:0] FTC_REFSRC_RST = 2'h0;
  localparam logic [15:0] FTC_FRACDEN_RST = 16'h0000;
  localparam logic FTC_FRACEN_RST = 1'b0;
  localparam logic [1:0] FTC_RSVD_RST = 2'h3;

  // output and feedback divider decode
  localparam logic [5:0] FTC_OUTDIV_MIN_CODE = 6'h03;
  localparam logic [6:0] FTC_OUTDIV_FALLBACK = 7'h04;
  localparam logic [6:0] FTC_FRATIO_MAX = 7'h10;

  // reference sources
  typedef enum logic [1:0] {
    FTC_SRC_MCLK_A = 2'h0,
    FTC_SRC_MCLK_B = 2'h1,
    FTC_SRC_FRAME_B = 2'h2,
    FTC_SRC_BIT_B = 2'h3
  } ftc_src_t;

  // pin sampling order
  localparam int FTC_PIN_COUNT = 5;
  localparam int FTC_PIN_MCLK_A = 0;
  localparam int FTC_PIN_MCLK_B = 1;
  localparam int FTC_PIN_FRAME_B = 2;
  localparam int FTC_PIN_BIT_B = 3;
  localparam int FTC_PIN_OSC = 4;

endpackage

/* File: test/ftc_fll_two_ctrl_tb.sv */
/*
 * ftc_fll_two_ctrl_tb: self-checking bench for the second loop's config block.
 * assumes the Avalon slave answers with one wait cycle; pins are made here.
 */
`timescale 1ns/1ps
module ftc_fll_two_ctrl_tb
  import ftc_pkg::*;
;
  logic CLK_IN = 1'b0;
  logic RST_N_IN = 1'b0;
  logic [11:0] ADDRESS_IN = '0;
  logic READ_IN = 1'b0;
  logic WRITE_IN = 1'b0;
  logic [31:0] WRITEDATA_IN = '0;
  logic [3:0] BYTEENABLE_IN = '0;
  logic [5:0] NORMAL_CONTROL_IN = '0;
  logic [4:0] pins = '0;
  wire [31:0] READDATA_OUT;
  wire WAITREQUEST_OUT;
  wire SYNTH_OUTPUT_CLOCK_OUT, REFERENCE_INPUT_CLOCK_OUT, FEEDBACK_CLOCK_OUT;
  wire [5:0] OSCILLATOR_CONTROL_OUT;
  wire [9:0] INTEGER_MULTIPLIER_OUT;
  wire [15:0] FRACTION_NUMERATOR_OUT, FRACTION_DENOMINATOR_OUT;
  wire FRACTIONAL_MODE_SELECT_OUT, LOOP_BYPASS_SELECT_OUT;
  wire [2:0] outs = {SYNTH_OUTPUT_CLOCK_OUT, REFERENCE_INPUT_CLOCK_OUT, FEEDBACK_CLOCK_OUT};
  int err_total = 0;
  int comparisons = 0;
  int seed = 45902;
  // half periods in system cycles; fastest source /1 is 12.5 MHz, under the limit
  int half [5] = '{4, 5, 6, 7, 3};
  int cnt [5] = '{0, 0, 0, 0, 0};
  logic [9:0] idx_tab [6] = '{FTC_IDX_OUT_DIV, FTC_IDX_FRAC_NUM, FTC_IDX_INT_MULT,
                              FTC_IDX_REF_SEL, FTC_IDX_FRAC_DEN, FTC_IDX_FRAC_MODE};
  logic [15:0] mask_tab [6] = '{16'h3F07, 16'hFFFF, 16'h7FE0, 16'h9FDB, 16'hFFFF, 16'h0007};
  logic [15:0] sh [6];
  logic [31:0] exp_q [$];

  ftc_fll_two_ctrl #(.DIV_W(7)) u_dut (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
    .ADDRESS_IN(ADDRESS_IN), .READ_IN(READ_IN), .WRITE_IN(WRITE_IN),
    .WRITEDATA_IN(WRITEDATA_IN), .BYTEENABLE_IN(BYTEENABLE_IN),
    .READDATA_OUT(READDATA_OUT), .WAITREQUEST_OUT(WAITREQUEST_OUT),
    .MASTER_CLOCK_IN_A_IN(pins[FTC_PIN_MCLK_A]), .MASTER_CLOCK_IN_B_IN(pins[FTC_PIN_MCLK_B]),
    .FRAME_CLOCK_PORT_B_IN(pins[FTC_PIN_FRAME_B]), .BIT_CLOCK_PORT_B_IN(pins[FTC_PIN_BIT_B]),
    .OSCILLATOR_CLOCK_IN(pins[FTC_PIN_OSC]), .NORMAL_CONTROL_IN(NORMAL_CONTROL_IN),
    .SYNTH_OUTPUT_CLOCK_OUT(SYNTH_OUTPUT_CLOCK_OUT), .REFERENCE_INPUT_CLOCK_OUT(REFERENCE_INPUT_CLOCK_OUT),
    .FEEDBACK_CLOCK_OUT(FEEDBACK_CLOCK_OUT), .OSCILLATOR_CONTROL_OUT(OSCILLATOR_CONTROL_OUT),
    .INTEGER_MULTIPLIER_OUT(INTEGER_MULTIPLIER_OUT), .FRACTION_NUMERATOR_OUT(FRACTION_NUMERATOR_OUT),
    .FRACTION_DENOMINATOR_OUT(FRACTION_DENOMINATOR_OUT),
    .FRACTIONAL_MODE_SELECT_OUT(FRACTIONAL_MODE_SELECT_OUT), .LOOP_BYPASS_SELECT_OUT(LOOP_BYPASS_SELECT_OUT)
  );

  initial begin
    forever #5 CLK_IN = ~CLK_IN;
  end

  // pins toggle from the system clock so every period is exact
  always @(posedge CLK_IN) begin
    for (int i = 0; i < 5; i++) begin
      if (cnt[i] >= half[i] - 1) begin
        cnt[i] <= 0;
        pins[i] <= ~pins[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // read data are noted at request time and judged when the slave answers
  always @(posedge CLK_IN) begin
    if (READ_IN === 1'b1 && WAITREQUEST_OUT === 1'b0) begin
      if (exp_q.size() == 0) begin
        check("unrequested read", 32'h0000_0001, 32'h0000_0000);
      end else begin
        check("readdata", READDATA_OUT, exp_q.pop_front());
      end
    end
  end

  // one Avalon access; request held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [9:0] idx, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge CLK_IN);
    ADDRESS_IN <= {idx, 2'b00};
    WRITEDATA_IN <= {16'h0000, d};
    BYTEENABLE_IN <= be;
    WRITE_IN <= wr;
    READ_IN <= ~wr;
    do begin
      @(posedge CLK_IN);
      n++;
    end while (WAITREQUEST_OUT !== 1'b0 && n < 100);
    WRITE_IN <= 1'b0;
    READ_IN <= 1'b0;
    if (n >= 100) check("waitrequest timeout", 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [15:0] exp);
    exp_q.push_back({16'h0000, exp});
    acc(1'b0, idx, 16'h0000, 4'hF);
  endtask

  task automatic wr(input int k, input logic [15:0] d, input logic [3:0] be);
    logic [15:0] bm;
    bm = {{8{be[1]}}, {8{be[0]}}};
    acc(1'b1, idx_tab[k], d, be);
    sh[k] = ((sh[k] & ~bm) | (d & bm)) & mask_tab[k];
  endtask

  task automatic check_fields();
    @(negedge CLK_IN);
    check("numerator", FRACTION_NUMERATOR_OUT, sh[1]);
    check("integer", INTEGER_MULTIPLIER_OUT, sh[2][14:5]);
    check("bypass", LOOP_BYPASS_SELECT_OUT, sh[3][15]);
    check("denominator", FRACTION_DENOMINATOR_OUT, sh[4]);
    check("mode", FRACTIONAL_MODE_SELECT_OUT, sh[5][0]);
    for (int k = 0; k < 6; k++) rd(idx_tab[k], sh[k]);
  endtask

  task automatic do_reset();
    @(posedge CLK_IN);
    RST_N_IN <= 1'b0;
    repeat (2) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    sh = '{16'h0000, 16'h0000, 16'h0000, 16'h0C80, 16'h0000, 16'h0006};
    // judged off the edge so the flops have settled
    @(negedge CLK_IN);
    check("reset waitrequest", WAITREQUEST_OUT, 1'b1);
    check("reset readdata", READDATA_OUT, 32'h0000_0000);
    check_fields();
  endtask

  // rising-to-rising span, skipping two rises so a ratio change settles
  task automatic measure(input int sel, output int per);
    int n;
    int rises;
    int t1;
    logic prev;
    n = 0;
    rises = 0;
    t1 = 0;
    prev = 1'b1;
    while (rises < 4 && n < 3000) begin
      @(posedge CLK_IN);
      n++;
      if (outs[sel] === 1'b1 && prev === 1'b0) begin
        rises++;
        if (rises == 3) t1 = n;
      end
      prev = outs[sel];
    end
    per = n - t1;
    // a stalled clock must never look like a good period
    if (rises < 4) per = -1;
  endtask

  initial begin
    int p;
    logic [15:0] d;
    logic [5:0] v;
    logic [3:0] be;
    int codes [5];
    codes = '{0, 2, 3, 5, 63};
    do_reset();
    for (int i = 0; i < 4; i++) begin
      // loop enable sits outside this block, so no field write ever follows it
      for (int k = 0; k < 6; k++) begin
        d = 16'($random(seed));
        be = 4'($random(seed));
        // reserved mode bits are always written back as one
        if (k == 5) d = d | 16'h0006;
        // fractional mode goes on whenever the numerator is nonzero
        if (k == 5 && sh[1] != 16'h0000) begin
          d[0] = 1'b1;
          be[0] = 1'b1;
        end
        wr(k, d, be);
      end
      check_fields();
    end
    acc(1'b1, 10'h245, 16'hFFFF, 4'hF);
    rd(10'h245, 16'h0000);
    rd(10'h240, 16'h0000);
    do_reset();
    v = 6'($random(seed));
    NORMAL_CONTROL_IN <= 6'h2A;
    wr(3, {3'b000, v, 1'b1, 6'h00}, 4'h3);
    repeat (2) @(negedge CLK_IN);
    check("forced osc", OSCILLATOR_CONTROL_OUT, v);
    wr(3, {3'b000, v, 1'b0, 6'h00}, 4'h3);
    repeat (2) @(negedge CLK_IN);
    check("normal osc", OSCILLATOR_CONTROL_OUT, 6'h2A);
    @(posedge CLK_IN);
    NORMAL_CONTROL_IN <= 6'($random(seed));
    repeat (2) @(negedge CLK_IN);
    check("normal osc", OSCILLATOR_CONTROL_OUT, NORMAL_CONTROL_IN);
    for (int c = 0; c < 8; c++) begin
      wr(0, 16'(c), 4'h3);
      measure(0, p);
      check("feedback period", p, 2 * half[4] * (c[2] ? 16 : (1 << c[1:0])));
    end
    foreach (codes[j]) begin
      wr(0, 16'(codes[j] << 8), 4'h3);
      measure(2, p);
      check("synth period", p, 2 * half[4] * (codes[j] < 3 ? 4 : codes[j] + 1));
    end
    for (int s = 0; s < 4; s++) begin
      // dividing below the limit is allowed, so every setting is taken
      for (int dv = 0; dv < 4; dv++) begin
        wr(3, 16'((dv << 3) | s), 4'h3);
        measure(1, p);
        check("reference period", p, 2 * half[s] * (1 << dv));
      end
    end
    wr(3, 16'h8000, 4'h3);
    measure(2, p);
    check("bypass period", p, 2 * half[FTC_PIN_BIT_B]);
    check_fields();
    repeat (4) @(posedge CLK_IN);
    check("reads answered", exp_q.size(), 0);
    end_of_test();
  end

  initial begin
    #1_000_000;
    err_total++;
    end_of_test();
  end
endmodule
